//--- rtl/ctlc_pkg.sv
// constants for the calibration trigger and low-power control block
package ctlc_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_PIN_CFG  = 10'h06b;
    localparam logic [9:0] IDX_SOFT_TRG = 10'h06c;
    localparam logic [9:0] IDX_LP_CTRL  = 10'h06e;
    localparam logic [9:0] IDX_GAIN     = 10'h07a;
    localparam logic [9:0] IDX_BG_CTRL  = 10'h090;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h091;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h092;

    // reset values
    localparam logic [7:0] RST_PIN_CFG  = 8'h00;
    localparam logic [7:0] RST_SOFT_TRG = 8'h01;
    localparam logic [7:0] RST_LP_CTRL  = 8'h88;
    localparam logic [7:0] RST_GAIN     = 8'h00;
    localparam logic [7:0] RST_BG_CTRL  = 8'h00;
    localparam logic [3:0] RST_IRQ      = 4'h0;

    // field positions
    localparam int SEL_LSB   = 1;
    localparam int SLEEP_LSB = 5;
    localparam int WAKE_LSB  = 3;
    localparam int PACED_BIT = 1;
    localparam int LPEN_BIT  = 0;

    // interrupt bits
    localparam int IRQ_FG    = 0;
    localparam int IRQ_HALT  = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_WAKE  = 3;

    localparam int TW = 41;

    // interval lengths in sample clock periods
    localparam logic [7:0][TW-1:0] SLEEP_CYCLES = {
        41'h100_0000_0080, 41'h020_0000_0080, 41'h004_0000_0080, 41'h000_8000_0080,
        41'h000_1000_0080, 41'h000_0200_0080, 41'h000_0040_0080, 41'h000_0000_0480};
    localparam logic [3:0][TW-1:0] WAKE_CYCLES = {
        41'h000_8000_0080, 41'h000_1000_0080, 41'h000_0200_0080, 41'h000_0000_0480};

    typedef enum logic [1:0] {
        LP_OFF    = 2'b00,
        LP_SLEEP  = 2'b01,
        LP_SETTLE = 2'b10,
        LP_CAL    = 2'b11
    } ctlc_state_type;

endpackage

//--- rtl/ctlc_ahb_slave.sv
// ahb-lite slave front end: zero-wait, registered read data
`timescale 1ns/1ps
`default_nettype none
module ctlc_ahb_slave (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // register side
    output logic      [9:0]  rd_idx,
    input  wire logic [7:0]  rd_data,
    output logic             wr_en,
    output logic      [9:0]  wr_idx,
    output logic      [7:0]  wr_data
);
    wire accept = hsel & htrans[1] & hready;

    logic       wpend_q;
    logic [9:0] widx_q;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rd_idx    = haddr[11:2];
    assign wr_en     = wpend_q;
    assign wr_idx    = widx_q;
    assign wr_data   = hwdata[7:0];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wpend_q <= 1'b0;
            widx_q  <= 10'h000;
            hrdata  <= 32'h0000_0000;
        end else begin
            wpend_q <= accept & hwrite;
            if (accept) begin
                widx_q <= haddr[11:2];
                hrdata <= hwrite ? 32'h0000_0000 : {24'h00_0000, rd_data};
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/ctlc_interval_timer.sv
// loadable down counter that stops at zero, timing sleep and settle intervals
`timescale 1ns/1ps
`default_nettype none
module ctlc_interval_timer (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // control
    input  wire logic                   load,
    input  wire logic [ctlc_pkg::TW-1:0] length,
    output logic                        expired
);
    import ctlc_pkg::*;

    logic [TW-1:0] cnt_q;

    assign expired = (cnt_q == '0);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= length - TW'(1);
        end else if (!expired) begin
            cnt_q <= cnt_q - TW'(1);
        end
    end
endmodule
`default_nettype wire

//--- rtl/ctlc_top.sv
// calibration trigger select, status pin routing and low-power sequencing
`timescale 1ns/1ps
`default_nettype none
module ctlc_top #(
    parameter logic [7:0][ctlc_pkg::TW-1:0] SLEEP_LEN = ctlc_pkg::SLEEP_CYCLES,
    parameter logic [3:0][ctlc_pkg::TW-1:0] WAKE_LEN  = ctlc_pkg::WAKE_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pins
    input  wire logic        hardware_trigger_pin,
    output logic             calibration_status_pin,
    // calibration engine
    input  wire logic        foreground_done,
    input  wire logic        bg_stopped,
    input  wire logic        alarm,
    input  wire logic        cal_complete,
    output logic             calibration_trigger,
    output logic             background_cal_enable,
    output logic             converter_sleep,
    output logic             converter_settling,
    output logic             cal_request,
    // interrupt
    output logic             irq
);
    import ctlc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus and registers

    logic [9:0] rd_idx;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [9:0] wr_idx;
    logic [7:0] wr_data;

    ctlc_ahb_slave u_bus (
        .clk       (clk),
        .rst_b     (rst_b),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rd_idx    (rd_idx),
        .rd_data   (rd_data),
        .wr_en     (wr_en),
        .wr_idx    (wr_idx),
        .wr_data   (wr_data)
    );

    logic [2:0] pin_cfg_q;
    logic       soft_trg_q;
    logic [7:0] lp_ctrl_q;
    logic [7:0] gain_q;
    logic       bg_en_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_stat_d;
    logic [3:0] irq_mask_q;

    function automatic logic wr_hit(input logic [9:0] idx);
        return wr_en && (wr_idx == idx);
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_cfg_q  <= RST_PIN_CFG[2:0];
            soft_trg_q <= RST_SOFT_TRG[0];
            lp_ctrl_q  <= RST_LP_CTRL;
            gain_q     <= RST_GAIN;
            bg_en_q    <= RST_BG_CTRL[0];
            irq_mask_q <= RST_IRQ;
        end else begin
            if (wr_hit(IDX_PIN_CFG))  pin_cfg_q  <= wr_data[2:0];
            if (wr_hit(IDX_SOFT_TRG)) soft_trg_q <= wr_data[0];
            if (wr_hit(IDX_LP_CTRL))  lp_ctrl_q  <= wr_data & 8'hfb;
            if (wr_hit(IDX_GAIN))     gain_q     <= wr_data;
            if (wr_hit(IDX_BG_CTRL))  bg_en_q    <= wr_data[0];
            if (wr_hit(IDX_IRQ_MASK)) irq_mask_q <= wr_data[3:0];
        end
    end

    wire       trig_src   = pin_cfg_q[0];
    wire [1:0] stat_sel   = pin_cfg_q[SEL_LSB +: 2];
    wire [2:0] sleep_code = lp_ctrl_q[SLEEP_LSB +: 3];
    wire [1:0] wake_code  = lp_ctrl_q[WAKE_LSB +: 2];
    wire       paced      = lp_ctrl_q[PACED_BIT];
    wire       low_power_cal_enable      = lp_ctrl_q[LPEN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // trigger and status

    assign calibration_trigger   = trig_src ? hardware_trigger_pin : soft_trg_q;
    assign background_cal_enable = bg_en_q;

    wire halted = bg_en_q ? bg_stopped : foreground_done;

    logic stat_d;
    always_comb begin
        case (stat_sel)
            2'd0:    stat_d = foreground_done;
            2'd1:    stat_d = halted;
            2'd2:    stat_d = alarm;
            default: stat_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calibration_status_pin <= 1'b0;
        end else begin
            calibration_status_pin <= stat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low-power sequencer

    ctlc_state_type state_q;
    ctlc_state_type state_d;

    wire lp_active = low_power_cal_enable & bg_en_q;

    logic          tmr_load;
    logic [TW-1:0] tmr_len;
    logic          tmr_expired;

    ctlc_interval_timer u_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (tmr_load),
        .length  (tmr_len),
        .expired (tmr_expired)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            LP_OFF: begin
                if (lp_active) state_d = LP_SLEEP;
            end
            LP_SLEEP: begin
                if (paced) begin
                    if (!calibration_trigger) state_d = LP_SETTLE;
                end else if (tmr_expired) begin
                    state_d = LP_SETTLE;
                end
            end
            LP_SETTLE: begin
                if (tmr_expired) state_d = LP_CAL;
            end
            LP_CAL: begin
                if (cal_complete) state_d = LP_SLEEP;
            end
            default: state_d = LP_OFF;
        endcase
        if (!lp_active) state_d = LP_OFF;
    end

    // reload the shared counter on every phase change
    assign tmr_load = (state_d != state_q);
    assign tmr_len  = (state_d == LP_SETTLE) ? WAKE_LEN[wake_code]
                                             : SLEEP_LEN[sleep_code];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= LP_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    assign converter_sleep    = (state_q == LP_SLEEP);
    assign converter_settling = (state_q == LP_SETTLE);
    assign cal_request        = (state_q == LP_CAL);

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    logic fg_prev_q;
    logic halt_prev_q;
    logic alarm_prev_q;

    wire [3:0] irq_evt = {(state_q == LP_SLEEP) && (state_d == LP_SETTLE),
                          alarm & ~alarm_prev_q,
                          halted & ~halt_prev_q,
                          foreground_done & ~fg_prev_q};
    // plain decode: a function call would hide wr_en and wr_idx from the net's update
    wire       clr_hit = wr_en && (wr_idx == IDX_IRQ_STAT);
    wire [3:0] irq_clr = clr_hit ? wr_data[3:0] : 4'h0;

    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
    assign irq        = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q   <= RST_IRQ;
            fg_prev_q    <= 1'b0;
            halt_prev_q  <= 1'b0;
            alarm_prev_q <= 1'b0;
        end else begin
            irq_stat_q   <= irq_stat_d;
            fg_prev_q    <= foreground_done;
            halt_prev_q  <= halted;
            alarm_prev_q <= alarm;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux

    assign rd_data =
        (rd_idx == IDX_PIN_CFG)  ? {5'h00, pin_cfg_q} :
        (rd_idx == IDX_SOFT_TRG) ? {7'h00, soft_trg_q} :
        (rd_idx == IDX_LP_CTRL)  ? lp_ctrl_q :
        (rd_idx == IDX_GAIN)     ? gain_q :
        (rd_idx == IDX_BG_CTRL)  ? {5'h00, halted, foreground_done, bg_en_q} :
        (rd_idx == IDX_IRQ_STAT) ? {4'h0, irq_stat_q} :
        (rd_idx == IDX_IRQ_MASK) ? {4'h0, irq_mask_q} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [TW-1:0] phase_cnt_q;
    logic [TW-1:0] phase_len_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_cnt_q <= '0;
            phase_len_q <= '0;
        end else if (tmr_load) begin
            phase_cnt_q <= '0;
            phase_len_q <= tmr_len;
        end else begin
            phase_cnt_q <= phase_cnt_q + TW'(1);
        end
    end

    sequence s_leave_timed_sleep;
        state_q == LP_SLEEP && !paced && lp_active && state_d == LP_SETTLE;
    endsequence

    sequence s_leave_settle;
        state_q == LP_SETTLE && lp_active && state_d == LP_CAL;
    endsequence

    property p_status_low;
        @(posedge clk) disable iff (!rst_b)
        stat_sel == 2'd3 |=> calibration_status_pin == 1'b0;
    endproperty
    a_status_low: assert property (p_status_low)
        else $error("status pin not low with select three");

    property p_status_alarm;
        @(posedge clk) disable iff (!rst_b)
        stat_sel == 2'd2 |=> calibration_status_pin == $past(alarm);
    endproperty
    a_status_alarm: assert property (p_status_alarm)
        else $error("status pin does not follow alarm");

    property p_trig_soft;
        @(posedge clk) disable iff (!rst_b)
        !trig_src |-> calibration_trigger == soft_trg_q;
    endproperty
    a_trig_soft: assert property (p_trig_soft)
        else $error("software trigger not selected");

    property p_trig_hw;
        @(posedge clk) disable iff (!rst_b)
        trig_src |-> calibration_trigger == hardware_trigger_pin;
    endproperty
    a_trig_hw: assert property (p_trig_hw)
        else $error("hardware trigger not selected");

    property p_sleep_len;
        @(posedge clk) disable iff (!rst_b)
        s_leave_timed_sleep |-> phase_cnt_q == phase_len_q - TW'(1);
    endproperty
    a_sleep_len: assert property (p_sleep_len)
        else $error("sleep interval length wrong");

    property p_settle_len;
        @(posedge clk) disable iff (!rst_b)
        s_leave_settle |-> phase_cnt_q == phase_len_q - TW'(1);
    endproperty
    a_settle_len: assert property (p_settle_len)
        else $error("settle interval length wrong");

    property p_paced_hold;
        @(posedge clk) disable iff (!rst_b)
        state_q == LP_SLEEP && paced && lp_active && calibration_trigger
            |=> state_q == LP_SLEEP;
    endproperty
    a_paced_hold: assert property (p_paced_hold)
        else $error("woke while trigger high");

    property p_lp_gate;
        @(posedge clk) disable iff (!rst_b)
        !lp_active |=> state_q == LP_OFF && !converter_sleep;
    endproperty
    a_lp_gate: assert property (p_lp_gate)
        else $error("low-power active without enables");

    property p_halted_fg;
        @(posedge clk) disable iff (!rst_b)
        !bg_en_q && stat_sel == 2'd1 |=> calibration_status_pin == $past(foreground_done);
    endproperty
    a_halted_fg: assert property (p_halted_fg)
        else $error("halted flag not following foreground_done");

endmodule
`default_nettype wire

//--- test/ctlc_host_model.sv
// host logic model: drives the trigger pin and completes woken-converter calibration
`timescale 1ns/1ps
`default_nettype none
module ctlc_host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // bench command
    input  wire logic trig_level,
    // block side
    input  wire logic cal_request,
    output logic      hardware_trigger_pin,
    output logic      cal_complete
);
    import ctlc_pkg::*;

    logic [1:0] cnt_q;

    // pin is a plain level, always driven by the host
    assign hardware_trigger_pin = trig_level;

    // one-cycle completion pulse after three cycles of request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q        <= 2'h0;
            cal_complete <= 1'b0;
        end else begin
            cal_complete <= cal_request && (cnt_q == 2'h2) && !cal_complete;
            cnt_q        <= (cal_request && !cal_complete) ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

//--- test/cal_trigger_lowpower_ctrl_tb.sv
// self-checking bench for the calibration trigger and low-power control block
`timescale 1ns/1ps
`default_nettype none
module cal_trigger_lowpower_ctrl_tb;
    import ctlc_pkg::*;

    localparam logic [7:0][TW-1:0] SL = {41'd27, 41'd26, 41'd25, 41'd24,
                                         41'd23, 41'd22, 41'd21, 41'd20};
    localparam logic [3:0][TW-1:0] WK = {41'd13, 41'd12, 41'd11, 41'd10};

    logic clk = 1'b0, rst_b = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, status_pin, trig, bg_en, c_sleep, c_settle, c_req, irq;
    logic trig_level = 1'b0, fg = 1'b0, bg_stopped = 1'b0, alarm = 1'b0;
    logic hw_pin, cal_done;
    int mismatches = 0, n_tests = 0, cyc = 0;

    always #5 clk = ~clk;

    ctlc_top #(.SLEEP_LEN(SL), .WAKE_LEN(WK)) dut (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .hardware_trigger_pin(hw_pin), .calibration_status_pin(status_pin),
        .foreground_done(fg), .bg_stopped(bg_stopped), .alarm(alarm),
        .cal_complete(cal_done), .calibration_trigger(trig),
        .background_cal_enable(bg_en), .converter_sleep(c_sleep),
        .converter_settling(c_settle), .cal_request(c_req), .irq(irq));

    ctlc_host_model host (
        .clk(clk), .rst_b(rst_b), .trig_level(trig_level), .cal_request(c_req),
        .hardware_trigger_pin(hw_pin), .cal_complete(cal_done));

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic [9:0] idx, input logic wr, input logic [7:0] d,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h0, idx, 2'b00};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(idx, 1'b1, d, x);
    endtask

    task automatic rchk(input logic [9:0] idx, input logic [7:0] exp, input string nm);
        logic [31:0] x;
        bus(idx, 1'b0, 8'h0, x);
        chk(nm, x, {24'h0, exp});
    endtask

    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    task automatic count_hi(ref logic s, output int n);
        n = 0;
        while (s === 1'b1 && n < 200) begin
            n++;
            tick(1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("trigger", trig, 1'b1);
        chk("hresp", hresp, 1'b0);
        rchk(IDX_PIN_CFG, RST_PIN_CFG, "pin_cfg");
        rchk(IDX_SOFT_TRG, RST_SOFT_TRG, "soft_trg");
        rchk(IDX_LP_CTRL, RST_LP_CTRL, "lp_ctrl");
        rchk(IDX_BG_CTRL, RST_BG_CTRL, "bg_ctrl");
        rchk(IDX_GAIN, RST_GAIN, "gain");
        wr(IDX_GAIN, 8'ha5);
        rchk(IDX_GAIN, 8'ha5, "gain_rw");
        rchk(10'h3ff, 8'h00, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_trigger();
        wr(IDX_SOFT_TRG, 8'h00);
        chk("soft_low", trig, 1'b0);
        trig_level <= 1'b1;
        tick(2);
        chk("pin_ignored", trig, 1'b0);
        wr(IDX_PIN_CFG, 8'h01);
        chk("pin_high", trig, 1'b1);
        wr(IDX_SOFT_TRG, 8'h01);
        trig_level <= 1'b0;
        tick(2);
        chk("soft_ignored", trig, 1'b0);
        wr(IDX_PIN_CFG, 8'h00);
        chk("soft_kept_high", trig, 1'b1);
        $display("test trigger done");
    endtask

    task automatic t_status();
        logic [3:0] expv;
        fg <= 1'b1;
        tick(2);
        expv = 4'b0011;
        for (int s = 0; s < 4; s++) begin
            wr(IDX_PIN_CFG, 8'(s << SEL_LSB));
            tick(2);
            chk("status_pin", status_pin, expv[s]);
        end
        alarm <= 1'b1;
        tick(2);
        chk("pin_sel3_low", status_pin, 1'b0);
        wr(IDX_PIN_CFG, 8'h04);
        tick(2);
        chk("pin_alarm", status_pin, 1'b1);
        wr(IDX_BG_CTRL, 8'h01);
        wr(IDX_PIN_CFG, 8'h02);
        tick(2);
        chk("pin_halted_bg", status_pin, 1'b0);
        chk("bg_enable", bg_en, 1'b1);
        bg_stopped <= 1'b1;
        tick(2);
        chk("pin_halted_stop", status_pin, 1'b1);
        rchk(IDX_BG_CTRL, 8'h07, "bg_ctrl_rd");
        bg_stopped <= 1'b0;
        rchk(IDX_IRQ_STAT, 8'h07, "irq_stat");
        chk("irq_masked", irq, 1'b0);
        wr(IDX_IRQ_MASK, 8'h01);
        chk("irq_on", irq, 1'b1);
        wr(IDX_IRQ_STAT, 8'h01);
        chk("irq_cleared", irq, 1'b0);
        rchk(IDX_IRQ_STAT, 8'h06, "irq_w1c");
        wr(IDX_IRQ_STAT, 8'h07);
        $display("test status done");
    endtask

    task automatic t_lowpower();
        int n;
        wr(IDX_BG_CTRL, 8'h00);
        wr(IDX_LP_CTRL, 8'h89);
        tick(5);
        chk("lp_needs_bg", c_sleep, 1'b0);
        wr(IDX_IRQ_MASK, 8'h08);
        wr(IDX_BG_CTRL, 8'h01);
        wait_hi(c_sleep, 10);
        count_hi(c_sleep, n);
        chk("sleep_len", n, 32'(SL[4]));
        chk("settling", c_settle, 1'b1);
        chk("wake_irq", irq, 1'b1);
        count_hi(c_settle, n);
        chk("settle_len", n, 32'(WK[1]));
        chk("cal_req", c_req, 1'b1);
        wr(IDX_IRQ_STAT, 8'h08);
        wr(IDX_LP_CTRL, 8'h11);
        // new codes apply from the next phase load: settle first, then the next sleep
        wait_hi(c_settle, 40);
        count_hi(c_settle, n);
        chk("settle_code2", n, 32'(WK[2]));
        wait_hi(c_sleep, 20);
        count_hi(c_sleep, n);
        chk("sleep_code0", n, 32'(SL[0]));
        $display("test lowpower done");
    endtask

    task automatic t_paced();
        wr(IDX_LP_CTRL, 8'h8b);
        wait_hi(c_sleep, 200);
        tick(40);
        chk("paced_asleep", c_sleep, 1'b1);
        wr(IDX_SOFT_TRG, 8'h00);
        wait_hi(c_settle, 4);
        chk("paced_wake", c_settle, 1'b1);
        wr(IDX_SOFT_TRG, 8'h01);
        wr(IDX_LP_CTRL, 8'h88);
        tick(2);
        chk("lp_off", {c_sleep, c_settle, c_req}, 3'b000);
        $display("test paced done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        t_reset();
        t_trigger();
        t_status();
        t_lowpower();
        t_paced();
        print_verdict();
    end
endmodule
`default_nettype wire
